// ===== rtl/lsa_pkg.sv
// shared constants and types for the screen addressing block
package lsa_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL = 6'h01;
	localparam logic [5:0] IDX_HSIZE = 6'h04;
	localparam logic [5:0] IDX_VSIZE_LO = 6'h05;
	localparam logic [5:0] IDX_VSIZE_HI = 6'h06;
	localparam logic [5:0] IDX_BIAS_RATE = 6'h0B;
	localparam logic [5:0] IDX_S1_LO = 6'h0C;
	localparam logic [5:0] IDX_S1_HI = 6'h0D;
	localparam logic [5:0] IDX_S2_LO = 6'h0E;
	localparam logic [5:0] IDX_S2_HI = 6'h0F;
	localparam logic [5:0] IDX_OVF = 6'h10;
	localparam logic [5:0] IDX_OFFSET = 6'h11;
	localparam logic [5:0] IDX_SPLIT_LO = 6'h12;
	localparam logic [5:0] IDX_SPLIT_HI = 6'h13;
	localparam logic [5:0] IDX_LUT_INDEX = 6'h15;
	localparam logic [5:0] IDX_LUT_DATA = 6'h17;
	localparam logic [5:0] IDX_ROT = 6'h1B;
	localparam logic [5:0] IDX_STRIDE = 6'h1C;
	localparam logic [5:0] IDX_STATUS = 6'h20;
	// field positions
	localparam int CTRL_ACTIVE_BIT = 7;
	localparam int ROT_ENABLE_BIT = 7;
	localparam int OVF_S1_BIT = 0;
	localparam int LUT_DATA_LSB = 4;
	localparam int STAT_BIAS_BIT = 0;
	localparam int STAT_SCREEN2_BIT = 1;
	localparam int STAT_VBLANK_BIT = 2;
	// field widths
	localparam int BIAS_RATE_W = 6;
	localparam int HSIZE_W = 7;
	localparam int VSIZE_HI_W = 2;
	localparam int ADDR_W = 17;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_SPLIT_LO = 8'hFF;
	localparam logic [1:0] RST_SPLIT_HI = 2'h3;
	// stride value zero means this many bytes
	localparam logic [8:0] STRIDE_ZERO = 9'h100;
	// ahb transfer types
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [2:0] {
		SEL_RED = 3'b001,
		SEL_GREEN = 3'b010,
		SEL_BLUE = 3'b100
	} lsa_colour_type;
endpackage

// ===== rtl/lsa_colour_lut.sv
// three colour look-up tables with a software port and a panel port
`timescale 1ns/1ns
module lsa_colour_lut #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 4
) (
	// clock
	input wire logic core_clk,
	// triple commit
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_index,
	input wire logic [WIDTH-1:0] wr_red,
	input wire logic [WIDTH-1:0] wr_green,
	input wire logic [WIDTH-1:0] wr_blue,
	// software read
	input wire logic [$clog2(DEPTH)-1:0] rd_index,
	output logic [WIDTH-1:0] rd_red,
	output logic [WIDTH-1:0] rd_green,
	output logic [WIDTH-1:0] rd_blue,
	// panel lookup, one cycle latency
	input wire logic [$clog2(DEPTH)-1:0] pix_index,
	output logic [3*WIDTH-1:0] pix_rgb
);
	initial begin
		if (DEPTH < 2 || WIDTH < 1) begin
			$error("lsa_colour_lut: bad size");
		end
	end
	logic [WIDTH-1:0] red_mem [DEPTH];
	logic [WIDTH-1:0] green_mem [DEPTH];
	logic [WIDTH-1:0] blue_mem [DEPTH];
	// one store per colour, entry written as a triple
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			red_mem[wr_index] <= wr_red;
			green_mem[wr_index] <= wr_green;
			blue_mem[wr_index] <= wr_blue;
		end
		pix_rgb <= {red_mem[pix_index], green_mem[pix_index], blue_mem[pix_index]};
	end
	assign rd_red = red_mem[rd_index];
	assign rd_green = green_mem[rd_index];
	assign rd_blue = blue_mem[rd_index];
endmodule

// ===== rtl/lsa_screen_regs.sv
// screen addressing, bias alternation and colour table registers
`timescale 1ns/1ns
module lsa_screen_regs #(
	parameter int LUT_DEPTH = 256,
	parameter int LUT_WIDTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// panel timing
	input wire logic frame_pulse,
	input wire logic line_pulse,
	input wire logic vblank,
	// panel outputs
	output logic bias_alternation_out,
	output logic [lsa_pkg::ADDR_W-1:0] line_addr,
	output logic screen2_active,
	// pixel colour lookup
	input wire logic [7:0] pix_index,
	output logic [3*LUT_WIDTH-1:0] pix_rgb
);
	initial begin
		if (LUT_DEPTH != 256 || LUT_WIDTH < 1 || LUT_WIDTH > 4) begin
			$error("lsa_screen_regs: lut size unsupported");
		end
	end
	// bus pipeline state
	logic wr_pend_q;
	logic rd_pend_q;
	logic [5:0] a_idx_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_mux;
	// software registers
	logic [7:0] ctrl_q;
	logic [lsa_pkg::HSIZE_W-1:0] hsize_q;
	logic [9:0] vsize_q;
	logic [lsa_pkg::BIAS_RATE_W-1:0] bias_rate_q;
	logic [15:0] s1_q;
	logic [15:0] s2_q;
	logic ovf_q;
	logic [7:0] offset_q;
	logic [9:0] split_q;
	logic rot_q;
	logic [7:0] stride_q;
	// colour pointer
	logic [7:0] lut_idx_q;
	lsa_pkg::lsa_colour_type sel_q;
	logic [3:0] stage_red_q;
	logic [3:0] stage_green_q;
	// frame shadows
	logic [15:0] sh_s2_q;
	logic [7:0] sh_offset_q;
	logic [9:0] sh_split_q;
	logic sh_rot_q;
	logic [lsa_pkg::HSIZE_W-1:0] sh_hsize_q;
	logic [7:0] sh_stride_q;
	// line walk and bias
	logic [9:0] line_cnt_q;
	logic [lsa_pkg::ADDR_W-1:0] line_addr_q;
	logic screen2_q;
	logic bias_q;
	logic [lsa_pkg::BIAS_RATE_W-1:0] bias_cnt_q;

	// bus decode
	wire accept = hsel && hready && (htrans == lsa_pkg::HTRANS_NONSEQ || htrans == 2'h3);
	wire [5:0] req_idx = haddr[7:2];
	wire wr_any = wr_pend_q;
	wire wr_ctrl = wr_any && a_idx_q == lsa_pkg::IDX_CTRL;
	wire wr_hsize = wr_any && a_idx_q == lsa_pkg::IDX_HSIZE;
	wire wr_vlo = wr_any && a_idx_q == lsa_pkg::IDX_VSIZE_LO;
	wire wr_vhi = wr_any && a_idx_q == lsa_pkg::IDX_VSIZE_HI;
	wire wr_rate = wr_any && a_idx_q == lsa_pkg::IDX_BIAS_RATE;
	wire wr_s1lo = wr_any && a_idx_q == lsa_pkg::IDX_S1_LO;
	wire wr_s1hi = wr_any && a_idx_q == lsa_pkg::IDX_S1_HI;
	wire wr_s2lo = wr_any && a_idx_q == lsa_pkg::IDX_S2_LO;
	wire wr_s2hi = wr_any && a_idx_q == lsa_pkg::IDX_S2_HI;
	wire wr_ovf = wr_any && a_idx_q == lsa_pkg::IDX_OVF;
	wire wr_offset = wr_any && a_idx_q == lsa_pkg::IDX_OFFSET;
	wire wr_splo = wr_any && a_idx_q == lsa_pkg::IDX_SPLIT_LO;
	wire wr_sphi = wr_any && a_idx_q == lsa_pkg::IDX_SPLIT_HI;
	wire wr_lidx = wr_any && a_idx_q == lsa_pkg::IDX_LUT_INDEX;
	wire wr_ldat = wr_any && a_idx_q == lsa_pkg::IDX_LUT_DATA;
	wire wr_rot = wr_any && a_idx_q == lsa_pkg::IDX_ROT;
	wire wr_stride = wr_any && a_idx_q == lsa_pkg::IDX_STRIDE;
	wire rd_ldat = rd_pend_q && a_idx_q == lsa_pkg::IDX_LUT_DATA;
	wire [7:0] wbyte = hwdata[7:0];
	wire [3:0] wcomp = hwdata[lsa_pkg::LUT_DATA_LSB +: 4];

	// bus pipeline: writes complete at once, reads take one wait state
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			a_idx_q <= 6'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= accept && hwrite;
			rd_pend_q <= accept && !hwrite;
			if (accept) begin
				a_idx_q <= req_idx;
			end
			if (rd_pend_q) begin
				hrdata_q <= rd_mux;
			end
		end
	end
	assign hreadyout = !rd_pend_q;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// colour table interface
	logic [LUT_WIDTH-1:0] lut_rd_red;
	logic [LUT_WIDTH-1:0] lut_rd_green;
	logic [LUT_WIDTH-1:0] lut_rd_blue;
	wire lut_commit = wr_ldat && sel_q == lsa_pkg::SEL_BLUE;
	wire [3:0] rd_comp = sel_q == lsa_pkg::SEL_RED ? 4'(lut_rd_red) :
		sel_q == lsa_pkg::SEL_GREEN ? 4'(lut_rd_green) : 4'(lut_rd_blue);

	lsa_colour_lut #(
		.DEPTH(LUT_DEPTH),
		.WIDTH(LUT_WIDTH)
	) u_lut (
		.core_clk(core_clk),
		.wr_en(lut_commit),
		.wr_index(lut_idx_q),
		.wr_red(LUT_WIDTH'(stage_red_q)),
		.wr_green(LUT_WIDTH'(stage_green_q)),
		.wr_blue(LUT_WIDTH'(wcomp)),
		.rd_index(lut_idx_q),
		.rd_red(lut_rd_red),
		.rd_green(lut_rd_green),
		.rd_blue(lut_rd_blue),
		.pix_index(pix_index),
		.pix_rgb(pix_rgb)
	);

	// read data selection
	wire [7:0] status_byte = {5'h00, vblank, screen2_q, bias_q};
	logic [7:0] rd_byte;
	always_comb begin
		unique case (a_idx_q)
			lsa_pkg::IDX_CTRL: rd_byte = ctrl_q;
			lsa_pkg::IDX_HSIZE: rd_byte = {1'b0, hsize_q};
			lsa_pkg::IDX_VSIZE_LO: rd_byte = vsize_q[7:0];
			lsa_pkg::IDX_VSIZE_HI: rd_byte = {6'h00, vsize_q[9:8]};
			lsa_pkg::IDX_BIAS_RATE: rd_byte = {2'h0, bias_rate_q};
			lsa_pkg::IDX_S1_LO: rd_byte = s1_q[7:0];
			lsa_pkg::IDX_S1_HI: rd_byte = s1_q[15:8];
			lsa_pkg::IDX_S2_LO: rd_byte = s2_q[7:0];
			lsa_pkg::IDX_S2_HI: rd_byte = s2_q[15:8];
			lsa_pkg::IDX_OVF: rd_byte = {7'h00, ovf_q};
			lsa_pkg::IDX_OFFSET: rd_byte = offset_q;
			lsa_pkg::IDX_SPLIT_LO: rd_byte = split_q[7:0];
			lsa_pkg::IDX_SPLIT_HI: rd_byte = {6'h00, split_q[9:8]};
			lsa_pkg::IDX_LUT_INDEX: rd_byte = lut_idx_q;
			lsa_pkg::IDX_LUT_DATA: rd_byte = {rd_comp, 4'h0};
			lsa_pkg::IDX_ROT: rd_byte = {rot_q, 7'h00};
			lsa_pkg::IDX_STRIDE: rd_byte = stride_q;
			lsa_pkg::IDX_STATUS: rd_byte = status_byte;
			default: rd_byte = 8'h00;
		endcase
	end
	assign rd_mux = {24'h00_0000, rd_byte};

	// software register file
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= lsa_pkg::RST_BYTE;
			hsize_q <= '0;
			vsize_q <= '0;
			bias_rate_q <= '0;
			s1_q <= '0;
			s2_q <= '0;
			ovf_q <= 1'b0;
			offset_q <= lsa_pkg::RST_BYTE;
			split_q <= {lsa_pkg::RST_SPLIT_HI, lsa_pkg::RST_SPLIT_LO};
			rot_q <= 1'b0;
			stride_q <= lsa_pkg::RST_BYTE;
		end else begin
			if (wr_ctrl) ctrl_q <= {wbyte[lsa_pkg::CTRL_ACTIVE_BIT], 7'h00};
			if (wr_hsize) hsize_q <= wbyte[lsa_pkg::HSIZE_W-1:0];
			if (wr_vlo) vsize_q[7:0] <= wbyte;
			if (wr_vhi) vsize_q[9:8] <= wbyte[lsa_pkg::VSIZE_HI_W-1:0];
			if (wr_rate) bias_rate_q <= wbyte[lsa_pkg::BIAS_RATE_W-1:0];
			if (wr_s1lo) s1_q[7:0] <= wbyte;
			if (wr_s1hi) s1_q[15:8] <= wbyte;
			if (wr_s2lo) s2_q[7:0] <= wbyte;
			if (wr_s2hi) s2_q[15:8] <= wbyte;
			if (wr_ovf) ovf_q <= wbyte[lsa_pkg::OVF_S1_BIT];
			if (wr_offset) offset_q <= wbyte;
			if (wr_splo) split_q[7:0] <= wbyte;
			if (wr_sphi) split_q[9:8] <= wbyte[lsa_pkg::VSIZE_HI_W-1:0];
			if (wr_rot) rot_q <= wbyte[lsa_pkg::ROT_ENABLE_BIT];
			if (wr_stride) stride_q <= wbyte;
		end
	end

	// colour pointer and staging
	wire lut_step = wr_ldat || rd_ldat;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lut_idx_q <= 8'h00;
			sel_q <= lsa_pkg::SEL_RED;
			stage_red_q <= 4'h0;
			stage_green_q <= 4'h0;
		end else if (wr_lidx) begin
			lut_idx_q <= wbyte;
			sel_q <= lsa_pkg::SEL_RED;
		end else if (lut_step) begin
			unique case (sel_q)
				lsa_pkg::SEL_RED: begin
					sel_q <= lsa_pkg::SEL_GREEN;
					if (wr_ldat) stage_red_q <= wcomp;
				end
				lsa_pkg::SEL_GREEN: begin
					sel_q <= lsa_pkg::SEL_BLUE;
					if (wr_ldat) stage_green_q <= wcomp;
				end
				lsa_pkg::SEL_BLUE: begin
					sel_q <= lsa_pkg::SEL_RED;
					lut_idx_q <= lut_idx_q + 8'h01;
				end
				default: sel_q <= lsa_pkg::SEL_RED;
			endcase
		end
	end

	// line address walk
	wire [9:0] next_line = line_cnt_q + 10'h001;
	wire split_now = !sh_rot_q && line_cnt_q == sh_split_q && sh_split_q < vsize_q;
	wire [8:0] rot_step = sh_stride_q == 8'h00 ? lsa_pkg::STRIDE_ZERO : {1'b0, sh_stride_q};
	wire [9:0] land_step = {3'h0, sh_hsize_q} + 10'h001 + {2'h0, sh_offset_q};
	wire [lsa_pkg::ADDR_W-1:0] addr_step = sh_rot_q ? {8'h00, rot_step} : {7'h00, land_step};
	wire [lsa_pkg::ADDR_W-1:0] frame_addr = rot_q ? {ovf_q, s1_q} : {1'b0, s1_q};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sh_s2_q <= '0;
			sh_offset_q <= '0;
			sh_split_q <= '0;
			sh_rot_q <= 1'b0;
			sh_hsize_q <= '0;
			sh_stride_q <= '0;
			line_cnt_q <= '0;
			line_addr_q <= '0;
			screen2_q <= 1'b0;
		end else if (frame_pulse) begin
			sh_s2_q <= s2_q;
			sh_offset_q <= offset_q;
			sh_split_q <= split_q;
			sh_rot_q <= rot_q;
			sh_hsize_q <= hsize_q;
			sh_stride_q <= stride_q;
			line_cnt_q <= '0;
			line_addr_q <= frame_addr;
			screen2_q <= 1'b0;
		end else if (line_pulse) begin
			line_cnt_q <= next_line;
			if (split_now) begin
				line_addr_q <= {1'b0, sh_s2_q};
				screen2_q <= 1'b1;
			end else begin
				line_addr_q <= line_addr_q + addr_step;
			end
		end
	end
	assign line_addr = line_addr_q;
	assign screen2_active = screen2_q;

	// bias alternation
	wire active_panel = ctrl_q[lsa_pkg::CTRL_ACTIVE_BIT];
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bias_q <= 1'b0;
			bias_cnt_q <= '0;
		end else if (active_panel) begin
			bias_q <= 1'b0;
			bias_cnt_q <= '0;
		end else if (bias_rate_q == '0) begin
			bias_cnt_q <= '0;
			if (frame_pulse) bias_q <= !bias_q;
		end else if (line_pulse) begin
			if (bias_cnt_q >= bias_rate_q) begin
				bias_q <= !bias_q;
				bias_cnt_q <= '0;
			end else begin
				bias_cnt_q <= bias_cnt_q + 6'h01;
			end
		end
	end
	assign bias_alternation_out = bias_q;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_bias_frame: assert property (!active_panel && bias_rate_q == '0 && frame_pulse |=> bias_q != $past(bias_q))
		else $error("bias did not toggle on frame");
	chk_bias_lines: assert property (!active_panel && bias_rate_q != '0 && line_pulse && bias_cnt_q == bias_rate_q
		&& !wr_rate && !wr_ctrl |=> bias_q != $past(bias_q) && bias_cnt_q == '0)
		else $error("bias did not toggle after line count");
	chk_bias_hold: assert property (!active_panel && bias_rate_q != '0 && !line_pulse && !wr_rate && !wr_ctrl
		|=> $stable(bias_q))
		else $error("bias moved without a line");
	chk_bias_active: assert property (active_panel |=> !bias_q)
		else $error("bias moving on active panel");
	chk_frame_land: assert property (frame_pulse && !rot_q |=> line_addr == {1'b0, $past(s1_q)})
		else $error("landscape frame start wrong");
	chk_frame_rot: assert property (frame_pulse && rot_q |=> line_addr == {$past(ovf_q), $past(s1_q)})
		else $error("rotated frame start wrong");
	chk_split_switch: assert property (line_pulse && !frame_pulse && split_now |=> line_addr == {1'b0, sh_s2_q}
		&& screen2_active)
		else $error("split did not switch screens");
	chk_rot_no_split: assert property (sh_rot_q && !frame_pulse |=> !screen2_active)
		else $error("second screen used while rotated");
	chk_offset_step: assert property (line_pulse && !frame_pulse && !split_now && !sh_rot_q |=>
		line_addr == 17'($past(line_addr) + {7'h00, $past(land_step)}))
		else $error("landscape line step wrong");
	chk_index_red: assert property (wr_lidx |=> sel_q == lsa_pkg::SEL_RED && lut_idx_q == $past(wbyte))
		else $error("index write did not reset pointer");
	chk_colour_step: assert property (lut_step && !wr_lidx && sel_q == lsa_pkg::SEL_BLUE |=>
		sel_q == lsa_pkg::SEL_RED && lut_idx_q == $past(lut_idx_q) + 8'h01)
		else $error("pointer did not wrap to next index");
	chk_commit_blue: assert property (wr_ldat && sel_q == lsa_pkg::SEL_BLUE |=>
		u_lut.blue_mem[$past(lut_idx_q)] == LUT_WIDTH'($past(wcomp))
		&& u_lut.red_mem[$past(lut_idx_q)] == LUT_WIDTH'($past(stage_red_q)))
		else $error("blue write did not commit the triple");
	chk_shadow_hold: assert property (!frame_pulse |=> $stable(sh_split_q) && $stable(sh_s2_q)
		&& $stable(sh_offset_q))
		else $error("shadow changed mid frame");
	cov_split: cover property (line_pulse && split_now);
	cov_triple: cover property (lut_commit);
	cov_bias_lines: cover property (line_pulse && bias_rate_q != '0 && bias_cnt_q == bias_rate_q);
	cov_rot_frame: cover property (frame_pulse && rot_q);
endmodule

// ===== tb/lsa_panel_model.sv
// panel timing source: line and frame pulses with blanking lines
`timescale 1ns/1ns
module lsa_panel_model #(
	parameter int LINE_CYC = 12,
	parameter int N_LINES = 8,
	parameter int BLANK_LINES = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// control
	input wire logic run,
	// timing outputs
	output logic frame_pulse,
	output logic line_pulse,
	output logic vblank
);
	int cyc_q;
	int line_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cyc_q <= 0;
			line_q <= 0;
		end else if (!run) begin
			cyc_q <= 0;
			line_q <= 0;
		end else if (cyc_q == LINE_CYC - 1) begin
			cyc_q <= 0;
			line_q <= (line_q == N_LINES + BLANK_LINES - 1) ? 0 : line_q + 1;
		end else begin
			cyc_q <= cyc_q + 1;
		end
	end
	// frame pulse mid-line so it never meets a line pulse
	assign frame_pulse = run && line_q == 0 && cyc_q == LINE_CYC / 2;
	assign line_pulse = run && cyc_q == LINE_CYC - 1;
	assign vblank = run && line_q >= N_LINES;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the screen addressing registers
`timescale 1ns/1ns
module testbench;
	logic core_clk, nrst, hsel, hwrite, hreadyout, hresp, run;
	logic [31:0] haddr, hwdata, hrdata, seed;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic frame_pulse, line_pulse, vblank, bias_alternation_out, screen2_active;
	logic [16:0] line_addr, e_addr;
	logic [7:0] pix_index, a, c;
	logic [11:0] pix_rgb;
	logic [7:0] regs_m [64];
	logic [11:0] lut_m [256];
	logic [7:0] cfg [5][4] = '{'{0, 0, 0, 3}, '{0, 0, 1, 8'hFF}, '{8'h80, 0, 4, 8'hFF}, '{0, 8'h80, 9, 2}, '{8'h80, 0, 0, 8'hFF}};
	logic [5:0] reg_list [12] = '{6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15, 6'h04, 6'h3F};
	logic e_s2, framed, pend, fchk, synced, b_prev, b_last, sh_ovf;
	logic [15:0] sh_s1, sh_s2;
	logic [7:0] sh_off;
	logic [9:0] sh_split;
	int mismatches = 0;
	int n_compared = 0;
	int e_cnt, lines_since, n;
	wire [15:0] m_s1 = {regs_m[lsa_pkg::IDX_S1_HI], regs_m[lsa_pkg::IDX_S1_LO]};
	wire [15:0] m_s2 = {regs_m[lsa_pkg::IDX_S2_HI], regs_m[lsa_pkg::IDX_S2_LO]};
	wire [9:0] m_split = {regs_m[lsa_pkg::IDX_SPLIT_HI][1:0], regs_m[lsa_pkg::IDX_SPLIT_LO]};
	wire [9:0] m_vsize = {regs_m[lsa_pkg::IDX_VSIZE_HI][1:0], regs_m[lsa_pkg::IDX_VSIZE_LO]};
	wire m_rot = regs_m[lsa_pkg::IDX_ROT][7];
	wire m_act = regs_m[lsa_pkg::IDX_CTRL][7];
	wire [5:0] m_rate = regs_m[lsa_pkg::IDX_BIAS_RATE][5:0];
	wire [7:0] m_stride = regs_m[lsa_pkg::IDX_STRIDE];
	wire [6:0] m_hsize = regs_m[lsa_pkg::IDX_HSIZE][6:0];

	lsa_screen_regs i_dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .frame_pulse(frame_pulse), .line_pulse(line_pulse), .vblank(vblank),
		.bias_alternation_out(bias_alternation_out), .line_addr(line_addr), .screen2_active(screen2_active),
		.pix_index(pix_index), .pix_rgb(pix_rgb));
	lsa_panel_model i_panel (.core_clk(core_clk), .nrst(nrst), .run(run), .frame_pulse(frame_pulse),
		.line_pulse(line_pulse), .vblank(vblank));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	function automatic logic [7:0] rnd8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	function automatic logic [7:0] mask_of(input logic [5:0] i);
		case (i)
			lsa_pkg::IDX_BIAS_RATE: return 8'h3F;
			lsa_pkg::IDX_OVF: return 8'h01;
			lsa_pkg::IDX_SPLIT_HI, lsa_pkg::IDX_VSIZE_HI: return 8'h03;
			lsa_pkg::IDX_HSIZE: return 8'h7F;
			lsa_pkg::IDX_CTRL, lsa_pkg::IDX_ROT: return 8'h80;
			6'h3F: return 8'h00;
			default: return 8'hFF;
		endcase
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic wait_rdy();
		int k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 100);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			print_verdict();
		end
	endtask

	task automatic bus(input logic wr, input logic [5:0] i, input logic [7:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= lsa_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {24'h0, i, 2'h0};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] v);
		logic [31:0] d;
		bus(1'b1, i, v, d);
		regs_m[i] = v & mask_of(i);
	endtask

	task automatic rd(input logic [5:0] i, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, i, 8'h00, d);
		check($sformatf("reg %h", i), d, e);
	endtask

	task automatic pix_check(input logic [7:0] i);
		@(posedge core_clk);
		pix_index <= i;
		@(posedge core_clk);
		@(negedge core_clk);
		check("pix_rgb", 32'(pix_rgb), 32'(lut_m[i]));
	endtask

	// expected line address, screen select and bias from the pulses
	always @(posedge core_clk) begin
		if (nrst === 1'b1 && run === 1'b1 && frame_pulse === 1'b1) begin
			framed = 1'b1;
			pend = 1'b1;
			fchk = 1'b1;
			b_prev = bias_alternation_out;
			e_cnt = 0;
			e_s2 = 1'b0;
			sh_s1 = m_s1;
			sh_s2 = m_s2;
			sh_ovf = regs_m[lsa_pkg::IDX_OVF][0];
			sh_off = regs_m[lsa_pkg::IDX_OFFSET];
			sh_split = m_split;
			e_addr = m_rot ? {sh_ovf, sh_s1} : {1'b0, sh_s1};
		end else if (nrst === 1'b1 && run === 1'b1 && line_pulse === 1'b1) begin
			lines_since++;
			if (framed) begin
				pend = 1'b1;
				if (!m_rot && e_cnt == sh_split && sh_split < m_vsize) begin
					e_addr = {1'b0, sh_s2};
					e_s2 = 1'b1;
				end else if (m_rot) e_addr = e_addr + (m_stride == 0 ? 17'h100 : 17'(m_stride));
				else e_addr = e_addr + 17'(m_hsize) + 17'h1 + 17'(sh_off);
				e_cnt++;
			end
		end
	end

	always @(negedge core_clk) begin
		if (pend) begin
			check("line_addr", 32'(line_addr), 32'(e_addr));
			check("screen2_active", 32'(screen2_active), 32'(e_s2));
			pend = 1'b0;
		end
		if (fchk) begin
			check("bias at frame", 32'(bias_alternation_out), 32'(m_act ? 1'b0 : (m_rate == 0) ^ b_prev));
			fchk = 1'b0;
		end
		if (bias_alternation_out !== b_last) begin
			if (synced && m_rate != 0 && !m_act) check("bias lines", lines_since, m_rate + 1);
			lines_since = 0;
			synced = 1'b1;
			b_last = bias_alternation_out;
		end
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end

	initial begin
		{nrst, hsel, hwrite, run, framed, pend, fchk, synced, b_last, e_s2} = '0;
		{haddr, hwdata, htrans, pix_index, lines_since} = '0;
		hsize = 3'h2;
		seed = 32'h22;
		foreach (regs_m[i]) regs_m[i] = 8'h00;
		regs_m[lsa_pkg::IDX_SPLIT_LO] = 8'hFF;
		regs_m[lsa_pkg::IDX_SPLIT_HI] = 8'h03;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		foreach (reg_list[k]) begin
			rd(reg_list[k], 32'(regs_m[reg_list[k]]));
			wr(reg_list[k], rnd8());
			rd(reg_list[k], 32'(regs_m[reg_list[k]]));
		end
		for (int k = 0; k < 3; k++) begin
			a = rnd8() % 8'hFE;
			wr(lsa_pkg::IDX_LUT_INDEX, a);
			for (int j = 0; j < 6; j++) begin
				c = rnd8();
				wr(lsa_pkg::IDX_LUT_DATA, c);
				lut_m[a + j / 3][11 - 4 * (j % 3) -: 4] = c[7:4];
			end
			pix_check(a);
			pix_check(a + 8'h01);
			wr(lsa_pkg::IDX_LUT_DATA, ~c);
			wr(lsa_pkg::IDX_LUT_INDEX, a);
			wr(lsa_pkg::IDX_LUT_DATA, ~c);
			wr(lsa_pkg::IDX_LUT_DATA, c ^ 8'h50);
			wr(lsa_pkg::IDX_LUT_INDEX, a);
			for (int j = 0; j < 6; j++) rd(lsa_pkg::IDX_LUT_DATA, {lut_m[a + j / 3][11 - 4 * (j % 3) -: 4], 4'h0});
			pix_check(a);
		end
		for (int k = 0; k < 5; k++) begin
			@(posedge core_clk);
			run <= 1'b0;
			framed = 1'b0;
			synced = 1'b0;
			rd(lsa_pkg::IDX_STATUS, {29'h0, 1'b0, e_s2, b_last});
			wr(lsa_pkg::IDX_ROT, cfg[k][0]);
			wr(lsa_pkg::IDX_CTRL, cfg[k][1]);
			wr(lsa_pkg::IDX_BIAS_RATE, cfg[k][2]);
			wr(lsa_pkg::IDX_SPLIT_LO, cfg[k][3]);
			wr(lsa_pkg::IDX_SPLIT_HI, cfg[k][3] == 8'hFF ? 8'h03 : 8'h00);
			wr(lsa_pkg::IDX_VSIZE_LO, 8'h07);
			wr(lsa_pkg::IDX_VSIZE_HI, 8'h00);
			wr(lsa_pkg::IDX_HSIZE, rnd8());
			wr(lsa_pkg::IDX_STRIDE, k == 2 ? 8'h00 : rnd8());
			for (int i = 12; i <= 17; i++) wr(6'(i), rnd8());
			@(posedge core_clk);
			run <= 1'b1;
			repeat (180) @(posedge core_clk);
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (line_pulse !== 1'b1 && n < 50);
			if (line_pulse !== 1'b1) begin
				mismatches++;
				print_verdict();
			end
			wr(lsa_pkg::IDX_S1_LO, rnd8());
			wr(lsa_pkg::IDX_OFFSET, rnd8());
			repeat (300) @(posedge core_clk);
		end
		print_verdict();
	end
endmodule
